// ### verilog/cangc_params.svh
// Function
// - control bit 5 set selects time-triggered operation; clear disables it
// - bit 4 set captures timer at last end-of-frame bit, else at start
// - capture-point bit only acts while time-triggered operation is selected
// - control bit 3 set enters listening mode; clearing it leaves it
// - control bit 1 set enables the controller and ungates its clock
// - on disable a running frame completes, then the engine freezes
// - standby: transmit stays recessive, receiver off, clock stopped
// - registers stay readable and writable while the controller is disabled
// - engine starts running two controller clocks after enable is set
// - soft reset bit 0 clears itself and is ORed with hardware reset
// - after either reset the controller comes up disabled
// - status bit 6 high while own overload frame is sent, no interrupt
// - status bit 4 high while transmitting or frame pending, no interrupt
// - status bit 3 high while receiver acquires or monitors, no interrupt
// - status bit 2 shows true enable state, lagging the command
// - all status bits read-only, including bus-off and error-passive
`ifndef CANGC_PARAMS_SVH
`define CANGC_PARAMS_SVH

// register offsets
`define CANGC_STAT_OFF   8'hAA
`define CANGC_CTRL_OFF   8'hAB
`define CANGC_IST_OFF    8'hE0
`define CANGC_IMSK_OFF   8'hE1

// control field positions
`define CANGC_C_TTC      5
`define CANGC_C_SYNC     4
`define CANGC_C_LISTEN   3
`define CANGC_C_TEST     2
`define CANGC_C_ENA      1
`define CANGC_C_SRST     0

// status field positions
`define CANGC_S_OVL      6
`define CANGC_S_TXB      4
`define CANGC_S_RXB      3
`define CANGC_S_ENF      2
`define CANGC_S_BUS_OFF_FLAG     1
`define CANGC_S_ERROR_PASSIVE_FLAG     0

// interrupt status field positions
`define CANGC_I_BUS_OFF_FLAG     0
`define CANGC_I_ERROR_PASSIVE_FLAG     1
`define CANGC_I_CAPT     2
`define CANGC_I_OBJECT_CHANNEL_ENABLE     3

// reset values and timing
`define CANGC_CTRL_RST   8'h00
`define CANGC_IRQ_RST    8'h00
`define CANGC_START_CYC  2'h2

`endif

// ### verilog/cangc_pkg.sv
`default_nettype none
package cangc_pkg;
  // enable sequencer states
  typedef enum logic [1:0] {
    ST_OFF,
    ST_START,
    ST_ON,
    ST_DRAIN
  } cangc_state_e;
endpackage
`default_nettype wire

// ### verilog/cangc_enable_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "cangc_params.svh"
module cangc_enable_seq (
  input  wire logic clock,       // system clock
  input  wire logic ctl_rst,     // combined reset, active high
  input  wire logic ena_cmd,     // commanded enable
  input  wire logic frame_busy,  // a frame is on the wire
  output logic      clk_on_q,    // controller clock ungated
  output logic      run_q,       // protocol engine running
  output logic      en_flag_q    // actual enable state
);
  cangc_pkg::cangc_state_e state_q, state_d;
  logic [1:0]              cnt_q;
  logic [1:0]              cnt_d;

  // next-state decode
  always_comb begin
    state_d = state_q;
    cnt_d   = 2'h0;
    case (state_q)
      cangc_pkg::ST_OFF: begin
        if (ena_cmd) state_d = cangc_pkg::ST_START;
      end
      cangc_pkg::ST_START: begin
        cnt_d = cnt_q + 2'h1;
        if (!ena_cmd) state_d = cangc_pkg::ST_OFF;
        else if (cnt_d == `CANGC_START_CYC) state_d = cangc_pkg::ST_ON;
      end
      cangc_pkg::ST_ON: begin
        if (!ena_cmd) state_d = cangc_pkg::ST_DRAIN;
      end
      cangc_pkg::ST_DRAIN: begin
        // let the running frame finish before freezing
        if (ena_cmd) state_d = cangc_pkg::ST_ON;
        else if (!frame_busy) state_d = cangc_pkg::ST_OFF;
      end
      default: state_d = cangc_pkg::ST_OFF;
    endcase
  end

  // state and flags, flags follow the next state so they match it
  always_ff @(posedge clock) begin
    if (ctl_rst) begin
      state_q   <= cangc_pkg::ST_OFF;
      cnt_q     <= 2'h0;
      clk_on_q  <= 1'b0;
      run_q     <= 1'b0;
      en_flag_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      clk_on_q  <= state_d != cangc_pkg::ST_OFF;
      run_q     <= state_d == cangc_pkg::ST_ON || state_d == cangc_pkg::ST_DRAIN;
      en_flag_q <= state_d == cangc_pkg::ST_ON || state_d == cangc_pkg::ST_DRAIN;
    end
  end

  start_delay_a: assert property (@(posedge clock) disable iff (ctl_rst)
    $rose(ena_cmd) && state_q == cangc_pkg::ST_OFF ##1 ena_cmd [*2]
      |-> !run_q ##1 run_q)
    else $error("engine start delay wrong");
  drain_hold_a: assert property (@(posedge clock) disable iff (ctl_rst)
    run_q && !ena_cmd && frame_busy |=> run_q)
    else $error("engine froze mid frame");
endmodule
`default_nettype wire

// ### verilog/cangc_top.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cangc_params.svh"
module cangc_top (
  input  wire logic        clock,         // 200 MHz system clock
  input  wire logic        nrst,          // synchronous reset, active low
  // register port
  input  wire logic [7:0]  addr,          // register address
  input  wire logic [7:0]  wdata,         // write data
  input  wire logic        wr,            // write strobe
  input  wire logic        rd,            // read strobe
  output logic      [7:0]  rdata_q,       // read data, cycle after rd
  // protocol engine status
  input  wire logic        overload_tx,   // own overload frame on wire
  input  wire logic        tx_busy,       // transmitter or pending frame
  input  wire logic        rx_busy,       // receiver acquires a frame
  input  wire logic        bus_off,       // bus-off state
  input  wire logic        err_passive,   // error-passive state
  input  wire logic        sof_seen,      // start-of-frame pulse
  input  wire logic        eof_last,      // last end-of-frame bit pulse
  // controls to the protocol engine
  output logic             ctl_reset_q,   // controller reset, active high
  output logic             clk_on_q,      // ungate controller clock
  output logic             run_q,         // engine runs, else frozen
  output logic             tt_mode_q,     // time-triggered operation
  output logic             listen_q,      // listening mode
  output logic             test_mode_q,   // factory test mode
  output logic             capture_q,     // capture trigger timer now
  output logic             tx_recessive_q,// force transmit recessive
  output logic             rx_enable_q,   // receiver active
  output logic             irq_q          // interrupt, active high level
);

  ////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = a == off;
  endfunction

  wire ctrl_sel = hit(addr, `CANGC_CTRL_OFF);
  wire stat_sel = hit(addr, `CANGC_STAT_OFF);
  wire ist_sel  = hit(addr, `CANGC_IST_OFF);
  wire imsk_sel = hit(addr, `CANGC_IMSK_OFF);

  wire ctrl_wr  = wr && ctrl_sel;
  wire imsk_wr  = wr && imsk_sel;
  wire ist_rd   = rd && ist_sel;

  ////////////////////////////////////////////////////////////////////////
  // control register

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic       soft_rst_q;
  logic       en_flag_q;
  logic       seq_clk_on;
  logic       seq_run;

  // soft reset pulse is one cycle; the bit never stores, so it reads zero
  wire  soft_req = ctrl_wr && wdata[`CANGC_C_SRST];
  wire  ctl_rst  = !nrst || soft_rst_q;

  // writable fields; abort and overload request bits are not kept here.
  // writes are taken in any enable state
  assign ctrl_d = ctrl_wr ? {2'h0, wdata[5:1], 1'b0} : ctrl_q;

  // soft reset also drops the control bits so the controller is disabled
  always_ff @(posedge clock) begin
    if (ctl_rst) begin
      ctrl_q <= `CANGC_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // the request flop itself is cleared only by hardware reset
  always_ff @(posedge clock) begin
    if (!nrst) begin
      soft_rst_q  <= 1'b0;
      ctl_reset_q <= 1'b1;
    end else begin
      soft_rst_q  <= soft_req;
      ctl_reset_q <= soft_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enable sequencer

  wire frame_busy = tx_busy || rx_busy;

  cangc_enable_seq u_seq (
    .clock      (clock),
    .ctl_rst    (ctl_rst),
    .ena_cmd    (ctrl_q[`CANGC_C_ENA]),
    .frame_busy (frame_busy),
    .clk_on_q   (seq_clk_on),
    .run_q      (seq_run),
    .en_flag_q  (en_flag_q)
  );

  assign clk_on_q = seq_clk_on;
  assign run_q    = seq_run;

  ////////////////////////////////////////////////////////////////////////
  // mode outputs and timer capture

  // capture point only matters in time-triggered mode
  wire capt_ev = ctrl_q[`CANGC_C_TTC] && seq_run &&
                 (ctrl_q[`CANGC_C_SYNC] ? eof_last : sof_seen);

  always_ff @(posedge clock) begin
    if (ctl_rst) begin
      tt_mode_q      <= 1'b0;
      listen_q       <= 1'b0;
      test_mode_q    <= 1'b0;
      capture_q      <= 1'b0;
      tx_recessive_q <= 1'b1;
      rx_enable_q    <= 1'b0;
    end else begin
      tt_mode_q      <= ctrl_d[`CANGC_C_TTC];
      listen_q       <= ctrl_d[`CANGC_C_LISTEN];
      test_mode_q    <= ctrl_d[`CANGC_C_TEST];
      capture_q      <= capt_ev;
      tx_recessive_q <= !seq_run;
      rx_enable_q    <= seq_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status register, built only from inputs and internal state

  wire [7:0] stat_val = {1'b0, overload_tx, 1'b0, tx_busy, rx_busy,
                         en_flag_q, bus_off, err_passive};
  // reserved bits 7 and 5 read zero

  ////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  logic [7:0] ist_q;
  logic [7:0] imsk_q;
  logic       bus_off_flag_q;
  logic       error_passive_flag_q;
  logic       enf_q;

  // overload and busy flags raise no interrupt; only the edges below, including enable flag changes
  wire [7:0] ev = {4'h0, enf_q != en_flag_q, capt_ev,
                   err_passive && !error_passive_flag_q, bus_off && !bus_off_flag_q};

  // set wins over the clear by read
  wire [7:0] ist_d = (ist_rd ? 8'h00 : ist_q) | ev;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ist_q  <= `CANGC_IRQ_RST;
      imsk_q <= `CANGC_IRQ_RST;
      bus_off_flag_q <= 1'b0;
      error_passive_flag_q <= 1'b0;
      enf_q  <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      ist_q  <= ist_d;
      imsk_q <= imsk_wr ? wdata : imsk_q;
      bus_off_flag_q <= bus_off;
      error_passive_flag_q <= err_passive;
      enf_q  <= en_flag_q;
      irq_q  <= |(ist_d & (imsk_wr ? wdata : imsk_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe and zero otherwise

  wire [7:0] rd_mux = ctrl_sel ? ctrl_q :
                      stat_sel ? stat_val :
                      ist_sel  ? ist_q :
                      imsk_sel ? imsk_q : 8'h00;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  tt_select_a: assert property (@(posedge clock) disable iff (!nrst)
    ctrl_wr && !wdata[`CANGC_C_SRST] && !soft_rst_q
      |=> tt_mode_q == $past(wdata[`CANGC_C_TTC]))
    else $error("time-triggered select not applied");

  capt_point_a: assert property (@(posedge clock) disable iff (!nrst)
    !ctl_rst && seq_run && ctrl_q[`CANGC_C_TTC] && ctrl_q[`CANGC_C_SYNC]
      && eof_last |=> capture_q)
    else $error("capture missed at end of frame");

  capt_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    !ctrl_q[`CANGC_C_TTC] |=> !capture_q)
    else $error("capture outside time-triggered mode");

  listen_mode_a: assert property (@(posedge clock) disable iff (!nrst)
    ctrl_wr && !wdata[`CANGC_C_SRST] && !soft_rst_q
      |=> listen_q == $past(wdata[`CANGC_C_LISTEN]))
    else $error("listen select not applied");

  standby_pins_a: assert property (@(posedge clock) disable iff (!nrst)
    !seq_clk_on ##1 !seq_clk_on |-> tx_recessive_q && !rx_enable_q)
    else $error("standby pins not quiet");

  soft_reset_a: assert property (@(posedge clock) disable iff (!nrst)
    soft_req |=> ctl_reset_q ##1 (!en_flag_q && ctrl_q == 8'h00))
    else $error("soft reset did not disable");

  srst_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    rd && ctrl_sel |=> !rdata_q[`CANGC_C_SRST])
    else $error("soft reset bit reads one");

  stat_ro_a: assert property (@(posedge clock) disable iff (!nrst)
    rd && stat_sel |=> rdata_q[`CANGC_S_BUS_OFF_FLAG] == $past(bus_off) &&
      rdata_q[`CANGC_S_ERROR_PASSIVE_FLAG] == $past(err_passive) &&
      rdata_q[`CANGC_S_OVL] == $past(overload_tx))
    else $error("status read not live");

  enf_lag_a: assert property (@(posedge clock) disable iff (!nrst)
    rd && stat_sel |=> rdata_q[`CANGC_S_ENF] == $past(en_flag_q))
    else $error("enable flag read wrong");

  irq_level_a: assert property (@(posedge clock) disable iff (!nrst)
    ##1 irq_q == |($past(ist_d) & $past(imsk_wr ? wdata : imsk_q)))
    else $error("interrupt level wrong");

endmodule
`default_nettype wire

// ### bench/cangc_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module cangc_link_model (
  input  wire logic       clock,       // system clock
  input  wire logic       nrst,        // synchronous reset, active low
  input  wire logic       go,          // start one frame on the bus
  input  wire logic [7:0] len,         // frame length in cycles, 3 or more
  input  wire logic [2:0] lvl,         // wanted {overload, bus-off, passive}
  output logic            overload_tx, // own overload frame on wire
  output logic            tx_busy,     // transmitter busy
  output logic            rx_busy,     // receiver monitors the frame
  output logic            bus_off,     // bus-off state
  output logic            err_passive, // error-passive state
  output logic            sof_seen,    // start-of-frame pulse
  output logic            eof_last     // last end-of-frame bit pulse
);
  logic [7:0] cnt_q; // cycles left in the running frame
  //////////////////////////////////////////////////////////////////////////
  // a frame keeps arriving even when the block is disabled, as on a bus
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
      sof_seen <= 1'b0;
      {overload_tx, bus_off, err_passive} <= 3'h0;
    end else begin
      cnt_q <= (go && cnt_q == 8'h00) ? len : cnt_q - {7'h00, cnt_q != 8'h00};
      sof_seen <= go && cnt_q == 8'h00;
      {overload_tx, bus_off, err_passive} <= lvl;
    end
  end
  // the node monitors its own frame, so both busy lines follow the frame
  assign tx_busy = cnt_q != 8'h00;
  assign rx_busy = cnt_q != 8'h00;
  assign eof_last = cnt_q == 8'h01;
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clock = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       go = 1'b0;
  logic [7:0] len = 8'h04;
  logic [2:0] lvl = 3'h0;
  logic [7:0] rdata_q, got;
  logic ovl, txb, rxb, bus_off_flag, error_passive_flag, sof, eof, sof_d, eof_d;
  logic ctl_reset_q, clk_on_q, run_q, tt_mode_q, listen_q, test_mode_q;
  logic capture_q, tx_recessive_q, rx_enable_q, irq_q;
  int num_errors = 0, samples_checked = 0, cap_sof = 0, cap_eof = 0;
  logic [7:0] cv[3] = '{8'h22, 8'h32, 8'h1A};
  logic [7:0] cs[3] = '{8'h01, 8'h00, 8'h00};
  logic [7:0] ce[3] = '{8'h00, 8'h01, 8'h00};

  always #2.5 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////
  cangc_top dut_u (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_q(rdata_q), .overload_tx(ovl), .tx_busy(txb),
    .rx_busy(rxb), .bus_off(bus_off_flag), .err_passive(error_passive_flag), .sof_seen(sof),
    .eof_last(eof), .ctl_reset_q(ctl_reset_q), .clk_on_q(clk_on_q),
    .run_q(run_q), .tt_mode_q(tt_mode_q), .listen_q(listen_q),
    .test_mode_q(test_mode_q), .capture_q(capture_q),
    .tx_recessive_q(tx_recessive_q), .rx_enable_q(rx_enable_q),
    .irq_q(irq_q));
  cangc_link_model link_u (.clock(clock), .nrst(nrst), .go(go), .len(len),
    .lvl(lvl), .overload_tx(ovl), .tx_busy(txb), .rx_busy(rxb),
    .bus_off(bus_off_flag), .err_passive(error_passive_flag), .sof_seen(sof), .eof_last(eof));
  //////////////////////////////////////////////////////////////////////////
  // count captures by the frame event that caused them one cycle before
  always @(posedge clock) begin
    sof_d <= sof;
    eof_d <= eof;
    if (capture_q && sof_d)
      cap_sof++;
    if (capture_q && eof_d)
      cap_eof++;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // read data is sampled in the one cycle where it stands
  task automatic rreg(input logic [7:0] a);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 got = rdata_q;
  endtask
  task automatic start(input logic [7:0] n);
    @(posedge clock);
    go <= 1'b1;
    len <= n;
    @(posedge clock);
    go <= 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    summarize();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    rreg(8'hAB);
    chk("ctrl", 8'h00, got);
    @(posedge clock);
    #1 chk("rdata idle", 8'h00, rdata_q);
    rreg(8'hAA);
    chk("status", 8'h00, got);
    chk("line", 8'h02, {6'h00, tx_recessive_q, rx_enable_q});
    wreg(8'h50, 8'hFF);
    rreg(8'h50);
    chk("unmapped", 8'h00, got);
    wreg(8'hAB, 8'h28); // test bit left clear
    rreg(8'hAB);
    chk("ctrl off", 8'h28, got);
    chk("modes", 8'h03, {5'h00, test_mode_q, tt_mode_q, listen_q});
    $display("test reset done");
    // enable and start-up delay
    wreg(8'hAB, 8'h02);
    @(posedge clock);
    #1 chk("run early", 8'h00, {7'h00, run_q});
    // line controls follow the running flag one cycle later
    repeat (3) @(posedge clock);
    #1 chk("on", 8'h0D, {4'h0, clk_on_q, run_q, tx_recessive_q,
                         rx_enable_q});
    rreg(8'hAA);
    chk("enf", 8'h04, got);
    rreg(8'hE0);
    $display("test enable done");
    // capture point per mode, capture unmasked to the interrupt
    wreg(8'hE1, 8'h04);
    for (int i = 0; i < 3; i++) begin
      wreg(8'hAB, cv[i]);
      cap_sof = 0;
      cap_eof = 0;
      start(8'h05);
      repeat (8) @(posedge clock);
      chk("modes", {6'h00, cv[i][5], cv[i][3]}, {6'h00, tt_mode_q, listen_q});
      chk("cap sof", cs[i], cap_sof[7:0]);
      chk("cap eof", ce[i], cap_eof[7:0]);
      chk("irq", cs[i] | ce[i], {7'h00, irq_q});
      rreg(8'hE0);
      chk("int", (cs[i] | ce[i]) << 2, got);
      @(posedge clock);
      #1 chk("irq clr", 8'h00, {7'h00, irq_q});
    end
    $display("test capture done");
    // status flags during a frame, masked events, read-only status
    wreg(8'hE1, 8'h00);
    lvl <= 3'h7;
    start(8'h14);
    rreg(8'hAA);
    chk("busy", 8'h5F, got);
    wreg(8'hAA, 8'h00); // a write of zeros leaves the status flags set
    rreg(8'hAA);
    chk("ro", 8'h5F, got);
    chk("irq mask", 8'h00, {7'h00, irq_q});
    rreg(8'hE0);
    chk("int", 8'h03, got);
    lvl <= 3'h0;
    repeat (20) @(posedge clock);
    $display("test status done");
    // disable with a frame running
    start(8'h1E);
    wreg(8'hAB, 8'h00);
    repeat (5) @(posedge clock);
    #1 chk("drain", 8'h01, {7'h00, run_q});
    repeat (30) @(posedge clock);
    #1 chk("off", 8'h01, {6'h00, run_q, tx_recessive_q});
    rreg(8'hAA);
    chk("enf off", 8'h00, got);
    $display("test disable done");
    // soft reset, then a hardware reset in mid-run
    wreg(8'hAB, 8'h02);
    repeat (4) @(posedge clock);
    wreg(8'hAB, 8'h23);
    // the reset pulse stands only in the cycle right after the write
    #1 chk("soft", 8'h01, {7'h00, ctl_reset_q});
    rreg(8'hAB);
    chk("ctrl sr", 8'h00, got);
    chk("run sr", 8'h00, {7'h00, run_q});
    wreg(8'hAB, 8'h02);
    repeat (4) @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rreg(8'hAB);
    chk("ctrl hr", 8'h00, got);
    chk("run hr", 8'h00, {7'h00, run_q});
    $display("test reset sources done");
    summarize();
  end
endmodule
`default_nettype wire
